/* src/sar_adc_pkg.sv */
// Constants and types for the successive-approximation converter control block
// Notes on behaviour
// - Each conversion resolves either an 8-bit or a 10-bit result, chosen by a resolution input.
// - The three clock-select bits pick the conversion clock as source/4, /2, /1, /1, /12, /6, /3 or /3.
// - Without sample-and-hold one pin takes 49 conversion-clock cycles at 8 bits and 59 at 10 bits.
// - With sample-and-hold one pin takes 28 conversion-clock cycles at 8 bits and 33 at 10 bits.
// - The result of input index i in any input group lands in result register i, for i from 0 to 7.
// - One-shot, repeat, single sweep, repeat sweep 0 and 1, simultaneous sweep and delayed trigger 0 and 1 exist.
// - With the ladder-connect bit at 0 the reference is cut off the resistor ladder and no current flows.
// - Under software trigger writing 1 to the start bit begins; under hardware trigger a falling pin edge begins.
// - A one-shot conversion ends with an interrupt pulse, clears the start bit under software trigger, and 0 halts.
package sar_adc_pkg;

    localparam int RESULT_W  = 10;
    localparam int CHAN_W    = 3;
    localparam int NUM_CHAN  = 8;
    localparam int DIV_W     = 4;
    localparam int CYC_W     = 6;

    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    // Conversion clock dividers, indexed by the three select bits
    localparam logic [DIV_W-1:0] DIV_SEL_000 = 4'h4;
    localparam logic [DIV_W-1:0] DIV_SEL_001 = 4'h2;
    localparam logic [DIV_W-1:0] DIV_SEL_01X = 4'h1;
    localparam logic [DIV_W-1:0] DIV_SEL_100 = 4'hc;
    localparam logic [DIV_W-1:0] DIV_SEL_101 = 4'h6;
    localparam logic [DIV_W-1:0] DIV_SEL_11X = 4'h3;

    // Conversion-clock cycles for one pin
    localparam logic [CYC_W-1:0] CYC_8B_NO_SH  = 6'h31; // 49
    localparam logic [CYC_W-1:0] CYC_10B_NO_SH = 6'h3b; // 59
    localparam logic [CYC_W-1:0] CYC_8B_SH     = 6'h1c; // 28
    localparam logic [CYC_W-1:0] CYC_10B_SH    = 6'h21; // 33
    localparam logic [CYC_W-1:0] BITS_8        = 6'h08;
    localparam logic [CYC_W-1:0] BITS_10       = 6'h0a;

    typedef enum logic [2:0] {
        MODE_ONE_SHOT     = 3'b000,
        MODE_REPEAT       = 3'b001,
        MODE_SINGLE_SWEEP = 3'b010,
        MODE_REP_SWEEP0   = 3'b011,
        MODE_REP_SWEEP1   = 3'b100,
        MODE_SIMUL_SWEEP  = 3'b101,
        MODE_DELAYED0     = 3'b110,
        MODE_DELAYED1     = 3'b111
    } conv_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARMED   = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_e;

endpackage : sar_adc_pkg

/* src/sar_adc_control.sv */
// Conversion clock prescaler, trigger handling, mode sequencing and SAR engine
`timescale 1ns/1ns
module sar_adc_control (
    // Clock and reset
    input  wire logic                              clk_sys_in,
    input  wire logic                              nrst_in,
    // Configuration
    input  wire logic                              conv_clk_sel_bit0_in,
    input  wire logic                              conv_clk_sel_bit1_in,
    input  wire logic                              conv_clk_sel_bit2_in,
    input  wire logic                              res_10bit_in,
    input  wire logic                              sample_hold_en_in,
    input  wire logic [2:0]                        mode_in,
    input  wire logic [sar_adc_pkg::CHAN_W-1:0]    channel_sel_in,
    input  wire logic [1:0]                        sweep_len_in,
    input  wire logic                              trigger_source_select_in,
    input  wire logic                              vref_ladder_connect_in,
    // Start bit write strobe
    input  wire logic                              start_write_in,
    input  wire logic                              start_value_in,
    // Trigger sources and comparator
    input  wire logic                              hw_trigger_pin_in,
    input  wire logic                              timer_trigger_in,
    input  wire logic                              comparator_in,
    // Result readback
    input  wire logic [sar_adc_pkg::CHAN_W-1:0]    result_index_in,
    output logic      [sar_adc_pkg::RESULT_W-1:0]  result_data_out,
    // Status and analog front end
    output logic                                   conversion_start_bit_out,
    output logic                                   busy_out,
    output logic                                   conv_irq_out,
    output logic      [sar_adc_pkg::CHAN_W-1:0]    channel_out,
    output logic                                   sample_out,
    output logic      [sar_adc_pkg::RESULT_W-1:0]  dac_code_out,
    output logic                                   vref_ladder_connect_out
);

    function automatic logic [sar_adc_pkg::DIV_W-1:0] div_of(input logic [2:0] sel);
        case (sel)
            3'b000:  div_of = sar_adc_pkg::DIV_SEL_000;
            3'b001:  div_of = sar_adc_pkg::DIV_SEL_001;
            3'b100:  div_of = sar_adc_pkg::DIV_SEL_100;
            3'b101:  div_of = sar_adc_pkg::DIV_SEL_101;
            3'b110,
            3'b111:  div_of = sar_adc_pkg::DIV_SEL_11X;
            default: div_of = sar_adc_pkg::DIV_SEL_01X;
        endcase
    endfunction : div_of

    logic [sar_adc_pkg::DIV_W-1:0]    div_cnt;
    logic [sar_adc_pkg::DIV_W-1:0]    next_div_cnt;
    logic                             tick;
    logic                             next_tick;
    sar_adc_pkg::conv_state_e         state;
    sar_adc_pkg::conv_state_e         next_state;
    logic                             start_bit;
    logic                             next_start_bit;
    logic [sar_adc_pkg::CYC_W-1:0]    cyc;
    logic [sar_adc_pkg::CYC_W-1:0]    next_cyc;
    logic [sar_adc_pkg::RESULT_W-1:0] trial;
    logic [sar_adc_pkg::RESULT_W-1:0] next_trial;
    logic [sar_adc_pkg::RESULT_W-1:0] probe;
    logic [sar_adc_pkg::RESULT_W-1:0] next_probe;
    logic [sar_adc_pkg::CHAN_W-1:0]   chan;
    logic [sar_adc_pkg::CHAN_W-1:0]   next_chan;
    logic                             next_irq;
    logic                             trig_prev;
    logic [sar_adc_pkg::RESULT_W-1:0] results [sar_adc_pkg::NUM_CHAN];
    logic [sar_adc_pkg::RESULT_W-1:0] next_results [sar_adc_pkg::NUM_CHAN];
    logic [sar_adc_pkg::RESULT_W-1:0] next_read;

    logic [sar_adc_pkg::CYC_W-1:0]    total_cyc;
    logic [sar_adc_pkg::CYC_W-1:0]    nbits;
    logic [sar_adc_pkg::CHAN_W-1:0]   sweep_last;
    logic                             trig_level;
    logic                             trig_fall;
    logic                             is_sweep;
    logic                             is_repeat;

    // Prescaler: one-cycle enable per conversion clock period
    always_comb begin
        next_tick    = 1'b0;
        next_div_cnt = div_cnt + 4'h1;
        if (div_cnt + 4'h1 >= div_of({conv_clk_sel_bit2_in, conv_clk_sel_bit1_in, conv_clk_sel_bit0_in})) begin
            next_div_cnt = 4'h0;
            next_tick    = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick    <= next_tick;
        end
    end

    // Per-pin timing and decoded mode attributes
    always_comb begin
        nbits = res_10bit_in ? sar_adc_pkg::BITS_10 : sar_adc_pkg::BITS_8;
        if (sample_hold_en_in) begin
            total_cyc = res_10bit_in ? sar_adc_pkg::CYC_10B_SH : sar_adc_pkg::CYC_8B_SH;
        end else begin
            total_cyc = res_10bit_in ? sar_adc_pkg::CYC_10B_NO_SH : sar_adc_pkg::CYC_8B_NO_SH;
        end
        sweep_last = {sweep_len_in, 1'b1};
        is_sweep   = (mode_in != sar_adc_pkg::MODE_ONE_SHOT) && (mode_in != sar_adc_pkg::MODE_REPEAT);
        is_repeat  = (mode_in == sar_adc_pkg::MODE_REPEAT) || (mode_in == sar_adc_pkg::MODE_REP_SWEEP0)
                     || (mode_in == sar_adc_pkg::MODE_REP_SWEEP1);
        // Timer underflows join the pin only in the delayed trigger modes
        trig_level = hw_trigger_pin_in;
        if ((mode_in == sar_adc_pkg::MODE_DELAYED0) || (mode_in == sar_adc_pkg::MODE_DELAYED1)) begin
            trig_level = hw_trigger_pin_in & ~timer_trigger_in;
        end
        trig_fall = trig_prev & ~trig_level;
    end

    // Sequencer and SAR engine
    always_comb begin
        next_state     = state;
        next_start_bit = start_bit;
        next_cyc       = cyc;
        next_trial     = trial;
        next_probe     = probe;
        next_chan      = chan;
        next_irq       = 1'b0;
        next_results   = results;
        case (state)
            sar_adc_pkg::ST_IDLE: begin
                if (start_write_in && start_value_in) begin
                    next_start_bit = 1'b1;
                    next_chan      = is_sweep ? 3'h0 : channel_sel_in;
                    next_cyc       = '0;
                    next_trial     = '0;
                    next_probe     = '0;
                    next_state     = trigger_source_select_in ? sar_adc_pkg::ST_ARMED
                                                              : sar_adc_pkg::ST_CONVERT;
                end
            end
            sar_adc_pkg::ST_ARMED: begin
                if (trig_fall) begin
                    next_state = sar_adc_pkg::ST_CONVERT;
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (tick) begin
                    next_cyc = cyc + 6'h01;
                    if (cyc == total_cyc - nbits - 6'h01) begin
                        next_probe = res_10bit_in ? 10'h200 : 10'h080;
                        next_trial = next_probe;
                    end else if (cyc >= total_cyc - nbits) begin
                        // Drop the probe bit when the input lies below the trial level
                        next_trial = comparator_in ? trial : (trial & ~probe);
                        next_probe = probe >> 1;
                        next_trial = next_trial | next_probe;
                    end
                    if (cyc == total_cyc - 6'h01) begin
                        next_results[chan] = comparator_in ? trial : (trial & ~probe);
                        next_cyc   = '0;
                        next_trial = '0;
                        next_probe = '0;
                        if (is_sweep && (chan != sweep_last)) begin
                            next_chan = chan + 3'h1;
                        end else if (is_repeat) begin
                            next_chan = is_sweep ? 3'h0 : chan;
                        end else begin
                            next_irq = 1'b1;
                            next_chan = is_sweep ? 3'h0 : chan;
                            if (trigger_source_select_in) begin
                                next_state = sar_adc_pkg::ST_ARMED;
                            end else begin
                                next_start_bit = 1'b0;
                                next_state     = sar_adc_pkg::ST_IDLE;
                            end
                        end
                    end
                end
            end
            default: begin
                next_state = sar_adc_pkg::ST_IDLE;
            end
        endcase
        // A write of 0 halts whatever is in progress
        if (start_write_in && !start_value_in) begin
            next_start_bit = 1'b0;
            next_state     = sar_adc_pkg::ST_IDLE;
            next_cyc       = '0;
            next_trial     = '0;
            next_probe     = '0;
            next_irq       = 1'b0;
        end
        next_read = next_results[result_index_in];
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state                    <= sar_adc_pkg::ST_IDLE;
            start_bit                <= 1'b0;
            cyc                      <= '0;
            trial                    <= '0;
            probe                    <= '0;
            chan                     <= '0;
            trig_prev                <= 1'b1;
            results                  <= '{default: sar_adc_pkg::RESULT_RESET};
            result_data_out          <= sar_adc_pkg::RESULT_RESET;
            conversion_start_bit_out <= 1'b0;
            busy_out                 <= 1'b0;
            conv_irq_out             <= 1'b0;
            channel_out              <= '0;
            sample_out               <= 1'b0;
            dac_code_out             <= '0;
            vref_ladder_connect_out  <= 1'b0;
        end else begin
            state                    <= next_state;
            start_bit                <= next_start_bit;
            cyc                      <= next_cyc;
            trial                    <= next_trial;
            probe                    <= next_probe;
            chan                     <= next_chan;
            trig_prev                <= trig_level;
            results                  <= next_results;
            result_data_out          <= next_read;
            conversion_start_bit_out <= next_start_bit;
            busy_out                 <= (next_state == sar_adc_pkg::ST_CONVERT);
            conv_irq_out             <= next_irq;
            channel_out              <= next_chan;
            sample_out               <= (next_state == sar_adc_pkg::ST_CONVERT) && (next_cyc < total_cyc - nbits);
            // The comparator DAC is full scale at 10 bits, so an 8-bit trial is left aligned
            dac_code_out             <= res_10bit_in ? next_trial : {next_trial[7:0], 2'b00};
            vref_ladder_connect_out  <= vref_ladder_connect_in;
        end
    end

endmodule : sar_adc_control

/* dv/sar_adc_control_monitor.sv */
// Port-level checker for the converter control block
`timescale 1ns/1ns
module sar_adc_control_monitor (
    input wire logic       clk_sys_in, nrst_in, res_10bit_in, trigger_source_select_in, vref_ladder_connect_in,
    input wire logic       start_write_in, start_value_in, hw_trigger_pin_in, timer_trigger_in,
    input wire logic [2:0] mode_in, channel_sel_in, channel_out,
    input wire logic       conversion_start_bit_out, busy_out, conv_irq_out, sample_out, vref_ladder_connect_out,
    input wire logic [9:0] dac_code_out
);
    // Longest one-shot: 59 ticks at divide-by-12, plus edge slack
    localparam logic [9:0] MAX_RUN = 10'h2c8;
    logic [9:0] busy_run;
    logic [9:0] next_busy_run;
    always_comb begin
        next_busy_run = busy_out ? busy_run + 10'h001 : 10'h000;
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_run <= 10'h000;
        end else begin
            busy_run <= next_busy_run;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    a_soft_start_go: assert property (start_write_in && start_value_in && !trigger_source_select_in
        && !conversion_start_bit_out && !busy_out |=> busy_out && conversion_start_bit_out)
        else $error("software start did not begin a conversion");
    a_hw_waits_edge: assert property (trigger_source_select_in && hw_trigger_pin_in && $past(hw_trigger_pin_in)
        && !busy_out && !timer_trigger_in && !start_write_in |=> !busy_out)
        else $error("conversion began without a trigger edge");
    a_halt_stops: assert property (start_write_in && !start_value_in
        |=> !busy_out && !conversion_start_bit_out && !conv_irq_out)
        else $error("writing zero did not halt");
    a_irq_one_pulse: assert property (conv_irq_out |=> !conv_irq_out)
        else $error("completion pulse longer than one cycle");
    a_irq_at_end: assert property (conv_irq_out |-> !busy_out && $past(busy_out))
        else $error("completion pulse without a finished conversion");
    a_sample_in_conv: assert property (sample_out |-> busy_out)
        else $error("sampling outside a conversion");
    a_one_pin_bound: assert property (mode_in == 3'b000 |-> busy_run <= MAX_RUN)
        else $error("one-pin conversion overran");
    a_dac_8bit_align: assert property (busy_out && !res_10bit_in |-> dac_code_out[1:0] == 2'b00)
        else $error("8-bit trial code not aligned");
    a_chan_follows_sel: assert property (busy_out && mode_in == 3'b000 |-> channel_out == channel_sel_in)
        else $error("converted channel differs from selection");
    a_sweep_from_zero: assert property ($rose(busy_out) && mode_in == 3'b010 |-> channel_out == 3'h0)
        else $error("sweep did not begin at channel zero");
    a_ladder_follow: assert property ($changed(vref_ladder_connect_in)
        |=> vref_ladder_connect_out == $past(vref_ladder_connect_in))
        else $error("ladder connect output did not follow");
    c_irq: cover property (conv_irq_out);
    c_halt: cover property (start_write_in && !start_value_in && busy_out);
    c_hw_start: cover property (trigger_source_select_in && $rose(busy_out));
endmodule : sar_adc_control_monitor
bind sar_adc_control sar_adc_control_monitor u_mon (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .res_10bit_in(res_10bit_in), .trigger_source_select_in(trigger_source_select_in),
    .vref_ladder_connect_in(vref_ladder_connect_in), .start_write_in(start_write_in), .start_value_in(start_value_in),
    .hw_trigger_pin_in(hw_trigger_pin_in), .timer_trigger_in(timer_trigger_in), .mode_in(mode_in),
    .channel_sel_in(channel_sel_in), .channel_out(channel_out), .conversion_start_bit_out(conversion_start_bit_out),
    .busy_out(busy_out), .conv_irq_out(conv_irq_out), .sample_out(sample_out),
    .vref_ladder_connect_out(vref_ladder_connect_out), .dac_code_out(dac_code_out));

/* dv/analog_source_model.sv */
// Analog inputs seen through an ideal comparator, one level per channel
`timescale 1ns/1ns
module analog_source_model (
    input  wire logic [7:0][9:0] levels_in,
    input  wire logic [2:0]      channel_in,
    input  wire logic [9:0]      dac_code_in,
    output logic                 comparator_out
);
    // Analog pins are only read, never driven, so they act as inputs
    always_comb begin
        comparator_out = (levels_in[channel_in] >= dac_code_in);
    end
endmodule : analog_source_model

/* dv/testbench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench;
    logic            clk_sys_in = 1'b0;
    logic            nrst_in = 1'b0;
    logic            res_10, sh_en, trig_sel, vref, st_wr, st_val, hw_pin, timer_trig, comp, irq_seen;
    logic [2:0]      sel, mode, ch, res_idx;
    logic [1:0]      sweep_len;
    logic [7:0][9:0] levels;
    logic [9:0]      result_data;
    logic            start_bit, busy, irq, sample, vref_out;
    logic [2:0]      chan;
    logic [9:0]      dac;
    int              seed, mismatches, n_compared, cyc, t, d, i, j, k;
    always #25 clk_sys_in = ~clk_sys_in;
    sar_adc_control DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .conv_clk_sel_bit0_in(sel[0]),
        .conv_clk_sel_bit1_in(sel[1]), .conv_clk_sel_bit2_in(sel[2]), .res_10bit_in(res_10),
        .sample_hold_en_in(sh_en), .mode_in(mode), .channel_sel_in(ch), .sweep_len_in(sweep_len),
        .trigger_source_select_in(trig_sel), .vref_ladder_connect_in(vref), .start_write_in(st_wr),
        .start_value_in(st_val), .hw_trigger_pin_in(hw_pin), .timer_trigger_in(timer_trig), .comparator_in(comp),
        .result_index_in(res_idx), .result_data_out(result_data), .conversion_start_bit_out(start_bit),
        .busy_out(busy), .conv_irq_out(irq), .channel_out(chan), .sample_out(sample), .dac_code_out(dac),
        .vref_ladder_connect_out(vref_out));
    analog_source_model u_src (.levels_in(levels), .channel_in(chan), .dac_code_in(dac), .comparator_out(comp));
    function automatic int div_of(input logic [2:0] s);
        case (s)
            3'h0: return 4;
            3'h1: return 2;
            3'h4: return 12;
            3'h5: return 6;
            3'h6, 3'h7: return 3;
            default: return 1;
        endcase
    endfunction : div_of
    function automatic logic [9:0] exp_result(input logic [9:0] lvl, input logic r10);
        return r10 ? lvl : {2'b00, lvl[9:2]};
    endfunction : exp_result
    // Repeat modes never finish on their own and raise no completion pulse
    function automatic logic is_rep(input logic [2:0] m);
        return (m == 3'h1) || (m == 3'h3) || (m == 3'h4);
    endfunction : is_rep
    task automatic cmp_val(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_val(what, {9'h000, exp}, {9'h000, got});
    endtask : cmp_bit
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #5;
    endtask : tick
    task automatic wr_start(input logic v);
        st_wr = 1'b1;
        st_val = v;
        tick(1);
        st_wr = 1'b0;
    endtask : wr_start
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic wait_irq(input int bound);
        cyc = 0;
        while (irq !== 1'b1) begin
            tick(1);
            cyc++;
            if (cyc > bound) begin
                mismatches++;
                $display("Error conv_irq_out expected 1 seen timeout");
                final_report();
            end
        end
    endtask : wait_irq
    initial begin
        {sel, mode, ch, res_idx, sweep_len, res_10, sh_en, trig_sel, vref, st_wr, st_val, timer_trig} = '0;
        hw_pin = 1'b1;
        levels = '0;
        seed = 32'hf0d6_aaf9;
        repeat (16) @(posedge clk_sys_in);
        #5;
        nrst_in = 1'b1;
        tick(1);
        for (j = 0; j < 6; j++) begin
            for (k = 0; k < 4; k++) begin
                // Undivided selects would exceed the 10 MHz ceiling from a 20 MHz source
                sel = 3'(j < 2 ? j : j + 2);
                {sh_en, res_10} = 2'(k);
                ch = 3'($random(seed));
                for (i = 0; i < 8; i++) levels[i] = 10'($random(seed));
                if (j == 0) levels[ch] = res_10 ? 10'h3ff : 10'h003;
                wr_start(1'b1);
                cmp_bit("sample_out", 1'b1, sample);
                wait_irq(800);
                d = div_of(sel);
                t = (sh_en ? (res_10 ? 33 : 28) : (res_10 ? 59 : 49)) * d;
                cmp_bit("conversion time", 1'b1, cyc >= t - d && cyc <= t + d + 2);
                cmp_bit("conversion_start_bit_out", 1'b0, start_bit);
                cmp_bit("sample_out idle", 1'b0, sample);
                res_idx = ch;
                tick(1);
                cmp_val("result_data_out", exp_result(levels[ch], res_10), result_data);
            end
        end
        $display("Test one_shot done");
        {mode, sweep_len, sel, res_10, sh_en} = {3'h2, 2'h3, 3'h0, 2'b11};
        for (i = 0; i < 8; i++) levels[i] = 10'($random(seed));
        wr_start(1'b1);
        wait_irq(1200);
        for (i = 0; i < 8; i++) begin
            res_idx = 3'(i);
            tick(1);
            cmp_val("sweep result_data_out", levels[i], result_data);
        end
        $display("Test sweep done");
        mode = 3'h0;
        irq_seen = 1'b0;
        wr_start(1'b1);
        tick(30);
        wr_start(1'b0);
        tick(1);
        cmp_bit("busy_out after halt", 1'b0, busy);
        for (i = 0; i < 400; i++) begin
            tick(1);
            irq_seen = irq_seen | irq;
        end
        cmp_bit("conv_irq_out after halt", 1'b0, irq_seen);
        $display("Test halt done");
        trig_sel = 1'b1;
        wr_start(1'b1);
        tick(10);
        cmp_bit("busy_out before edge", 1'b0, busy);
        hw_pin = 1'b0;
        tick(3);
        cmp_bit("busy_out after edge", 1'b1, busy);
        wait_irq(800);
        hw_pin = 1'b1;
        cmp_bit("conversion_start_bit_out armed", 1'b1, start_bit);
        wr_start(1'b0);
        tick(1);
        $display("Test hw_trigger done");
        sweep_len = 2'h0;
        for (k = 1; k < 8; k++) begin
            mode = 3'(k);
            // Delayed modes wait for a timer underflow, so they run under hardware trigger
            trig_sel = mode[2] & mode[1];
            wr_start(1'b1);
            tick(2);
            cmp_bit("busy_out before timer", ~trig_sel, busy);
            timer_trig = trig_sel;
            tick(1);
            timer_trig = 1'b0;
            tick(4);
            cmp_bit("busy_out in mode", 1'b1, busy);
            irq_seen = 1'b0;
            for (i = 0; i < 300; i++) begin
                tick(1);
                irq_seen = irq_seen | irq;
            end
            cmp_bit("busy_out repeating", is_rep(3'(k)), busy);
            cmp_bit("conv_irq_out per mode", ~is_rep(3'(k)), irq_seen);
            wr_start(1'b0);
            tick(1);
        end
        trig_sel = 1'b0;
        $display("Test modes done");
        vref = 1'b1;
        tick(2);
        cmp_bit("vref_ladder_connect_out", 1'b1, vref_out);
        vref = 1'b0;
        tick(2);
        cmp_bit("vref_ladder_connect_out", 1'b0, vref_out);
        $display("Test ladder done");
        final_report();
    end
endmodule : testbench
